// File: design/sample_clock_defines.svh
`ifndef SAMPLE_CLOCK_DEFINES_SVH
`define SAMPLE_CLOCK_DEFINES_SVH

// ==========================================================
// Clock rates
`define SCS_CLK_HZ 32'd10000000
`define SCS_BASE_HZ 32'd51200
`define SCS_DIV_MAX 9'd256
`define SCS_DIV_MIN 9'd1

// ==========================================================
// Synchronisation and measurement
`define SCS_SYNC_CYCLES 8'd128
`define SCS_MEAS_EDGES 8'd16
`define SCS_DIV_STEPS 6'd32

// ==========================================================
// Source encodings and identity
`define SCS_SRC_LOCAL 2'h0
`define SCS_SRC_MASTER 2'h1
`define SCS_SRC_SLAVE 2'h2
`define SCS_FW_VERSION 16'h0100

`endif

// File: design/sample_clock_pkg.sv
`include "sample_clock_defines.svh"

package sample_clock_pkg;

    typedef enum logic [1:0] {
        SRC_LOCAL = `SCS_SRC_LOCAL,
        SRC_MASTER = `SCS_SRC_MASTER,
        SRC_SLAVE = `SCS_SRC_SLAVE
    } clock_source_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DIV_Q = 3'b001,
        ST_PICK = 3'b011,
        ST_DIV_R = 3'b010,
        ST_SYNC = 3'b110,
        ST_MEAS = 3'b111,
        ST_DIV_M = 3'b101
    } dev_state_t;

endpackage

// File: design/sample_clock_link_if.sv
`timescale 1ns/1ps

interface sample_clock_link_if;
    import sample_clock_pkg::*;

    logic cfg_wr;
    clock_source_t cfg_src;
    logic [16:0] cfg_rate;
    clock_source_t stat_src;
    logic [16:0] stat_rate;
    logic stat_synced;
    logic iepe_wr;
    logic iepe_ch;
    logic iepe_val;
    logic iepe_ack;
    logic iepe_busy;
    logic [1:0] iepe_cfg;
    logic [15:0] fw_version;
    logic scan_active;
    logic line_i;
    logic line_o;
    logic line_oe;

    modport device (
        input cfg_wr, cfg_src, cfg_rate, iepe_wr, iepe_ch, iepe_val, scan_active, line_i,
        output stat_src, stat_rate, stat_synced, iepe_ack, iepe_busy, iepe_cfg,
        output fw_version, line_o, line_oe
    );

    modport host (
        output cfg_wr, cfg_src, cfg_rate, iepe_wr, iepe_ch, iepe_val, scan_active,
        input stat_src, stat_rate, stat_synced, iepe_ack, iepe_busy, iepe_cfg, fw_version
    );

endinterface

// File: design/sample_clock_host.sv
`timescale 1ns/1ps

module sample_clock_host (
    input wire logic clk,
    input wire logic sys_rst,
    sample_clock_link_if.host link,
    input wire logic req_go,
    input wire sample_clock_pkg::clock_source_t req_src,
    input wire logic [16:0] req_rate,
    input wire logic rewrite,
    input wire logic slaves_configured,
    input wire logic other_master,
    input wire logic iepe_go,
    input wire logic iepe_ch_in,
    input wire logic iepe_val_in,
    input wire logic scan_start,
    input wire logic scan_stop,
    output logic req_refused,
    output logic synced,
    output logic [16:0] actual_rate
);
    import sample_clock_pkg::*;

    clock_source_t last_src_reg;
    logic [16:0] last_rate_reg;
    logic master_ok;

    // ==========================================================
    // Configuration ordering
    assign master_ok = slaves_configured & ~other_master;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.cfg_wr <= 1'b0;
            link.cfg_src <= SRC_LOCAL;
            link.cfg_rate <= 17'h0c800;
            last_src_reg <= SRC_LOCAL;
            last_rate_reg <= 17'h0c800;
            req_refused <= 1'b0;
        end else begin
            link.cfg_wr <= 1'b0;
            req_refused <= 1'b0;
            if (req_go) begin
                if (req_src == SRC_MASTER && !master_ok) begin
                    req_refused <= 1'b1;
                end else begin
                    link.cfg_wr <= 1'b1;
                    link.cfg_src <= req_src;
                    link.cfg_rate <= req_rate;
                    last_src_reg <= req_src;
                    last_rate_reg <= req_rate;
                end
            end else if (rewrite) begin
                link.cfg_wr <= 1'b1;
                link.cfg_src <= last_src_reg;
                link.cfg_rate <= last_rate_reg;
            end
        end
    end

    // ==========================================================
    // Sensor power and scan state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.iepe_wr <= 1'b0;
            link.iepe_ch <= 1'b0;
            link.iepe_val <= 1'b0;
            link.scan_active <= 1'b0;
        end else begin
            link.iepe_wr <= iepe_go;
            link.iepe_ch <= iepe_ch_in;
            link.iepe_val <= iepe_val_in;
            if (scan_start) begin
                link.scan_active <= 1'b1;
            end else if (scan_stop) begin
                link.scan_active <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Status capture
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            synced <= 1'b0;
            actual_rate <= 17'h0;
        end else begin
            synced <= link.stat_synced;
            actual_rate <= link.stat_rate;
        end
    end

endmodule

// File: design/sample_clock_device.sv
`timescale 1ns/1ps
`include "sample_clock_defines.svh"

// Summary of operation
// - Sample clock is base rate over 1..256
// - Request maps to nearest rate, read back
// - Local or master reads the adjusted rate
// - Reset default: local source, full base rate
// - Sources: local, master drives line, slave follows
// - Both converters synchronised on one strobe
// - First sample after 128 sample clocks
// - Synced flag: 0 in progress, 1 done
// - Slave measures master rate after sync
// - Slave rate invalid while synced is zero
// - Slave follows master edges in sync, measurement and sampling
// - Configure slaves first, master triggers sync
// - At most one master on shared line
// - Late change loses alignment; rewrite every board
// - Slave without master never delivers samples
// - Use trigger to align all data streams
// - Power writes refused busy during a scan
// - Version is BCD, major high byte
module sample_clock_device #(
    parameter logic [15:0] FW_VERSION = `SCS_FW_VERSION
) (
    input wire logic clk,
    input wire logic sys_rst,
    sample_clock_link_if.device link,
    output logic adc_sync,
    output logic sample_strobe,
    output logic [1:0] iepe_power
);
    import sample_clock_pkg::*;

    localparam logic [31:0] BASE = `SCS_BASE_HZ;
    localparam logic [31:0] CLKF = `SCS_CLK_HZ;

    dev_state_t state_reg;
    clock_source_t src_reg;
    logic [16:0] req_reg;
    logic [8:0] div_reg;
    logic [16:0] rate_reg;
    logic synced_reg;
    logic [1:0] iepe_reg;
    logic [23:0] acc_reg;
    logic [24:0] acc_sum;
    logic base_tick;
    logic [8:0] cnt_reg;
    logic own_tick;
    logic line_o_reg;
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic master_edge;
    logic src_tick;
    logic sync_start;
    logic [7:0] sync_cnt_reg;
    logic [7:0] edge_cnt_reg;
    logic [31:0] meas_cnt_reg;
    logic div_load;
    logic [31:0] div_num;
    logic [31:0] div_den;
    logic [31:0] num_reg;
    logic [31:0] den_reg;
    logic [31:0] quo_reg;
    logic [32:0] rem_reg;
    logic [32:0] rem_sh;
    logic [5:0] step_reg;
    logic [8:0] pick_div;
    logic [47:0] lhs;
    logic [47:0] rhs;

    function automatic logic [16:0] sat_rate(input logic [31:0] q);
        sat_rate = (q > 32'h0001ffff) ? 17'h1ffff : q[16:0];
    endfunction

    // ==========================================================
    // Base tick and sample divider
    assign acc_sum = {1'b0, acc_reg} + BASE[24:0];
    assign base_tick = (acc_sum >= CLKF[24:0]);
    assign own_tick = base_tick && (cnt_reg >= div_reg - 9'd1);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_reg <= 24'h0;
            cnt_reg <= 9'h0;
        end else if (sync_start) begin
            acc_reg <= 24'h0;
            cnt_reg <= 9'h0;
        end else begin
            acc_reg <= base_tick ? 24'(acc_sum - CLKF[24:0]) : acc_sum[23:0];
            if (base_tick) begin
                cnt_reg <= own_tick ? 9'h0 : cnt_reg + 9'd1;
            end
        end
    end

    // ==========================================================
    // Shared clock line
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_o_reg <= 1'b0;
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            line_o_reg <= own_tick;
            sync1_reg <= link.line_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign master_edge = sync2_reg & ~sync3_reg;
    assign link.line_o = line_o_reg;
    assign link.line_oe = (src_reg == SRC_MASTER);
    assign src_tick = (src_reg == SRC_SLAVE) ? master_edge : own_tick;

    // ==========================================================
    // Divisor selection
    always_comb begin
        lhs = 48'(req_reg) * 48'(quo_reg[8:0]) * 48'({1'b0, quo_reg[8:0]} + 10'd1);
        lhs = lhs << 1;
        rhs = 48'(BASE) * 48'({quo_reg[8:0], 1'b1});
        if (quo_reg == 32'h0) begin
            pick_div = `SCS_DIV_MIN;
        end else if (quo_reg >= 32'(`SCS_DIV_MAX)) begin
            pick_div = `SCS_DIV_MAX;
        end else if (lhs >= rhs) begin
            pick_div = quo_reg[8:0];
        end else begin
            pick_div = quo_reg[8:0] + 9'd1;
        end
    end

    always_comb begin
        div_load = 1'b0;
        div_num = BASE;
        div_den = BASE;
        sync_start = 1'b0;
        if (link.cfg_wr) begin
            div_load = 1'b1;
            div_den = (link.cfg_rate == 17'h0) ? 32'h1 : 32'(link.cfg_rate);
        end else if (state_reg == ST_PICK) begin
            div_load = 1'b1;
            div_den = 32'(pick_div);
        end else if (state_reg == ST_DIV_R && step_reg == 6'h0) begin
            sync_start = 1'b1;
        end else if (state_reg == ST_MEAS && master_edge
                     && edge_cnt_reg == `SCS_MEAS_EDGES - 8'd1) begin
            div_load = 1'b1;
            div_num = CLKF * 32'(`SCS_MEAS_EDGES);
            div_den = meas_cnt_reg + 32'd1;
        end
    end

    // ==========================================================
    // Sequential divider
    assign rem_sh = {rem_reg[31:0], num_reg[31]};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            num_reg <= 32'h0;
            den_reg <= 32'h1;
            quo_reg <= 32'h0;
            rem_reg <= 33'h0;
            step_reg <= 6'h0;
        end else if (div_load) begin
            num_reg <= div_num;
            den_reg <= div_den;
            quo_reg <= 32'h0;
            rem_reg <= 33'h0;
            step_reg <= `SCS_DIV_STEPS;
        end else if (step_reg != 6'h0) begin
            num_reg <= num_reg << 1;
            step_reg <= step_reg - 6'd1;
            if (rem_sh >= {1'b0, den_reg}) begin
                rem_reg <= rem_sh - {1'b0, den_reg};
                quo_reg <= {quo_reg[30:0], 1'b1};
            end else begin
                rem_reg <= rem_sh;
                quo_reg <= {quo_reg[30:0], 1'b0};
            end
        end
    end

    // ==========================================================
    // Configuration, synchronisation and measurement
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_SYNC;
            src_reg <= SRC_LOCAL;
            req_reg <= 17'h0c800;
            div_reg <= `SCS_DIV_MIN;
            rate_reg <= 17'h0c800;
            synced_reg <= 1'b0;
            sync_cnt_reg <= 8'h0;
            edge_cnt_reg <= 8'h0;
            meas_cnt_reg <= 32'h0;
        end else if (link.cfg_wr) begin
            state_reg <= ST_DIV_Q;
            src_reg <= link.cfg_src;
            req_reg <= link.cfg_rate;
            synced_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_DIV_Q: begin
                    if (step_reg == 6'h0) begin
                        state_reg <= ST_PICK;
                    end
                end
                ST_PICK: begin
                    div_reg <= pick_div;
                    state_reg <= ST_DIV_R;
                end
                ST_DIV_R: begin
                    if (step_reg == 6'h0) begin
                        if (src_reg != SRC_SLAVE) begin
                            rate_reg <= sat_rate(quo_reg);
                        end
                        sync_cnt_reg <= 8'h0;
                        state_reg <= ST_SYNC;
                    end
                end
                ST_SYNC: begin
                    if (src_tick) begin
                        sync_cnt_reg <= sync_cnt_reg + 8'd1;
                        if (sync_cnt_reg == `SCS_SYNC_CYCLES - 8'd1) begin
                            edge_cnt_reg <= 8'h0;
                            meas_cnt_reg <= 32'h0;
                            if (src_reg == SRC_SLAVE) begin
                                state_reg <= ST_MEAS;
                            end else begin
                                synced_reg <= 1'b1;
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_MEAS: begin
                    meas_cnt_reg <= meas_cnt_reg + 32'd1;
                    if (master_edge) begin
                        edge_cnt_reg <= edge_cnt_reg + 8'd1;
                        if (edge_cnt_reg == `SCS_MEAS_EDGES - 8'd1) begin
                            state_reg <= ST_DIV_M;
                        end
                    end
                end
                ST_DIV_M: begin
                    if (step_reg == 6'h0) begin
                        rate_reg <= sat_rate(quo_reg);
                        synced_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Converter strobes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            adc_sync <= 1'b0;
            sample_strobe <= 1'b0;
        end else begin
            adc_sync <= sync_start;
            sample_strobe <= synced_reg & src_tick & ~sync_start;
        end
    end

    // ==========================================================
    // Excitation power
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            iepe_reg <= 2'b00;
            link.iepe_ack <= 1'b0;
            link.iepe_busy <= 1'b0;
        end else begin
            link.iepe_ack <= 1'b0;
            link.iepe_busy <= 1'b0;
            if (link.iepe_wr) begin
                if (link.scan_active) begin
                    link.iepe_busy <= 1'b1;
                end else begin
                    iepe_reg[link.iepe_ch] <= link.iepe_val;
                    link.iepe_ack <= 1'b1;
                end
            end
        end
    end

    assign iepe_power = iepe_reg;
    assign link.iepe_cfg = iepe_reg;
    assign link.stat_src = src_reg;
    assign link.stat_rate = rate_reg;
    assign link.stat_synced = synced_reg;
    assign link.fw_version = FW_VERSION;

endmodule

// File: verif/sample_clock_properties.sv
`timescale 1ns/1ps

module sample_clock_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_wr,
    input wire sample_clock_pkg::clock_source_t cfg_src,
    input wire sample_clock_pkg::clock_source_t stat_src,
    input wire logic [16:0] stat_rate,
    input wire logic stat_synced,
    input wire logic iepe_wr,
    input wire logic iepe_ch,
    input wire logic iepe_val,
    input wire logic iepe_ack,
    input wire logic iepe_busy,
    input wire logic [1:0] iepe_cfg,
    input wire logic [15:0] fw_version,
    input wire logic scan_active,
    input wire logic line_o,
    input wire logic line_oe
);
    import sample_clock_pkg::*;

    // ==========================================================
    // Cycles since the last configuration write
    logic [31:0] since_cfg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            since_cfg <= 32'h0;
        end else if (cfg_wr) begin
            since_cfg <= 32'h0;
        end else if (since_cfg != 32'hffffffff) begin
            since_cfg <= since_cfg + 32'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Assertions
    a_line_master_only: assert property (line_oe |-> stat_src == SRC_MASTER)
        else $error("shared line driven outside master mode");
    a_src_follows: assert property (cfg_wr |=> stat_src == $past(cfg_src))
        else $error("clock source not taken from write");
    a_sync_restart: assert property (cfg_wr |=> !stat_synced)
        else $error("synced flag not cleared by write");
    a_sync_length: assert property ($rose(stat_synced) |-> since_cfg >= 32'd24000)
        else $error("sync finished before 128 sample clocks");
    a_synced_holds: assert property (stat_synced && !cfg_wr |=> stat_synced)
        else $error("synced flag dropped without a write");
    a_iepe_accept: assert property (iepe_wr && !scan_active |=>
        iepe_ack && !iepe_busy && iepe_cfg[$past(iepe_ch)] == $past(iepe_val))
        else $error("power write not applied");
    a_iepe_refuse: assert property (iepe_wr && scan_active |=>
        iepe_busy && !iepe_ack && $stable(iepe_cfg))
        else $error("power write during scan not refused");
    a_fw_bcd: assert property (fw_version[15:12] <= 4'h9 && fw_version[11:8] <= 4'h9
        && fw_version[7:4] <= 4'h9 && fw_version[3:0] <= 4'h9)
        else $error("version not decimal coded");
    a_rate_range: assert property (stat_synced && stat_src != SRC_SLAVE |->
        stat_rate >= 17'd200 && stat_rate <= 17'd51200)
        else $error("rate outside divider range");
    a_line_pulse: assert property (line_oe && line_o |=> !line_o)
        else $error("master tick wider than one cycle");

    // ==========================================================
    // Coverage
    c_slave_cfg: cover property (cfg_wr && cfg_src == SRC_SLAVE);
    c_busy: cover property (iepe_wr && scan_active);
    c_master_sync: cover property ($rose(stat_synced) && stat_src == SRC_MASTER);
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps

module tb;
    import sample_clock_pkg::*;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_go = 1'b0, rewrite = 1'b0, slaves_configured = 1'b0, other_master = 1'b0;
    logic iepe_go = 1'b0, iepe_ch_in = 1'b0, iepe_val_in = 1'b0;
    logic scan_start = 1'b0, scan_stop = 1'b0, ext_line = 1'b0, master_on = 1'b0;
    clock_source_t req_src = SRC_LOCAL;
    logic [16:0] req_rate = 17'h0;
    logic req_refused, synced, adc_sync, sample_strobe;
    logic [16:0] actual_rate;
    logic [1:0] iepe_power;
    logic [1:0] exp_iepe = 2'h0;
    logic scan_on = 1'b0;
    int errors = 0, total_checks = 0, cycles = 0, mcnt = 0;
    int refused_cnt = 0, sync_cnt = 0, tick_cnt = 0, strobe_cnt = 0;
    int rates[6] = '{51200, 200, 0, 100000, 25600, 17000};
    int d, e, i;

    sample_clock_link_if link ();
    assign link.line_i = link.line_oe ? link.line_o : ext_line;

    sample_clock_host sample_clock_host_i (.clk(clk), .sys_rst(sys_rst), .link(link),
        .req_go(req_go), .req_src(req_src), .req_rate(req_rate), .rewrite(rewrite),
        .slaves_configured(slaves_configured), .other_master(other_master),
        .iepe_go(iepe_go), .iepe_ch_in(iepe_ch_in), .iepe_val_in(iepe_val_in),
        .scan_start(scan_start), .scan_stop(scan_stop), .req_refused(req_refused),
        .synced(synced), .actual_rate(actual_rate));
    sample_clock_device sample_clock_device_i (.clk(clk), .sys_rst(sys_rst), .link(link),
        .adc_sync(adc_sync), .sample_strobe(sample_strobe), .iepe_power(iepe_power));
    sample_clock_properties checker_i (.clk(clk), .sys_rst(sys_rst), .cfg_wr(link.cfg_wr),
        .cfg_src(link.cfg_src), .stat_src(link.stat_src), .stat_rate(link.stat_rate),
        .stat_synced(link.stat_synced), .iepe_wr(link.iepe_wr), .iepe_ch(link.iepe_ch),
        .iepe_val(link.iepe_val), .iepe_ack(link.iepe_ack), .iepe_busy(link.iepe_busy),
        .iepe_cfg(link.iepe_cfg), .fw_version(link.fw_version),
        .scan_active(link.scan_active), .line_o(link.line_o), .line_oe(link.line_oe));

    always #50 clk = ~clk;

    // ==========================================================
    // Other board's master clock, one-cycle pulse every 200 cycles
    always @(negedge clk) begin
        mcnt <= (mcnt == 199) ? 0 : mcnt + 1;
        ext_line <= master_on && (mcnt == 0);
    end

    // ==========================================================
    // Event counters and run limit
    always @(posedge clk) begin
        cycles++;
        if (req_refused === 1'b1) refused_cnt++;
        if (adc_sync === 1'b1) sync_cnt++;
        if (sync_cnt > 0 && link.line_o === 1'b1 && link.stat_synced === 1'b0) tick_cnt++;
        if (sample_strobe === 1'b1) strobe_cnt++;
        if (cycles >= 80000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic req(input clock_source_t s, input logic [16:0] r);
        @(negedge clk);
        req_src = s;
        req_rate = r;
        req_go = 1'b1;
        @(negedge clk);
        req_go = 1'b0;
        tick(100);
    endtask

    task automatic scan(input logic on);
        @(negedge clk);
        scan_start = on;
        scan_stop = !on;
        @(negedge clk);
        scan_start = 1'b0;
        scan_stop = 1'b0;
        scan_on = on;
        tick(3);
    endtask

    task automatic iepe(input logic ch, input logic v);
        @(negedge clk);
        iepe_ch_in = ch;
        iepe_val_in = v;
        iepe_go = 1'b1;
        @(negedge clk);
        iepe_go = 1'b0;
        tick(4);
        if (!scan_on) exp_iepe[ch] = v;
        chk({30'h0, link.iepe_cfg}, {30'h0, exp_iepe});
        chk({30'h0, iepe_power}, {30'h0, exp_iepe});
    endtask

    task automatic wait_sync(input int lim);
        for (int k = 0; k < lim && link.stat_synced !== 1'b1; k++) @(negedge clk);
    endtask

    function automatic int nearest_div(input int r);
        int q;
        q = 51200 / ((r <= 0) ? 1 : r);
        if (q >= 256) return 256;
        if (q == 0) return 1;
        if ((51200 - r * q) * (q + 1) <= (r * (q + 1) - 51200) * q) return q;
        return q + 1;
    endfunction

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(20430));
        repeat (16) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        tick(2);
        chk(link.stat_src, SRC_LOCAL);
        chk(link.stat_rate, 32'd51200);
        chk(link.stat_synced, 32'h0);
        chk(link.fw_version, 32'h0100);
        for (i = 0; i < 12; i++) begin
            if (i == 4) scan(1'b1);
            if (i == 8) scan(1'b0);
            iepe(1'($urandom), 1'($urandom));
        end
        for (i = 0; i < 12; i++) begin
            if (i < 6) e = rates[i];
            else e = $urandom_range(1, 60000);
            req(SRC_LOCAL, 17'(e));
            d = nearest_div(e);
            e = 51200 / d;
            chk(actual_rate, e);
            chk(link.stat_rate, e);
        end
        refused_cnt = 0;
        req(SRC_MASTER, 17'd51200);
        chk(refused_cnt, 1);
        chk(link.stat_src, SRC_LOCAL);
        slaves_configured = 1'b1;
        other_master = 1'b1;
        refused_cnt = 0;
        req(SRC_MASTER, 17'd51200);
        chk(refused_cnt, 1);
        other_master = 1'b0;
        sync_cnt = 0;
        tick_cnt = 0;
        req(SRC_MASTER, 17'd51200);
        wait_sync(30000);
        chk(link.stat_synced, 32'h1);
        chk(link.stat_src, SRC_MASTER);
        chk(link.line_oe, 32'h1);
        chk(sync_cnt, 1);
        chk(tick_cnt >= 127 && tick_cnt <= 129, 1);
        strobe_cnt = 0;
        tick(600);
        chk(strobe_cnt >= 2, 1);
        chk(synced, 32'h1);
        chk(actual_rate, 32'd51200);
        req(SRC_SLAVE, 17'd51200);
        tick(2000);
        chk(link.stat_synced, 32'h0);
        chk(link.line_oe, 32'h0);
        master_on = 1'b1;
        wait_sync(40000);
        chk(link.stat_synced, 32'h1);
        tick(3);
        chk(actual_rate, 32'd50000);
        @(negedge clk) rewrite = 1'b1;
        @(negedge clk) rewrite = 1'b0;
        tick(3);
        chk(link.stat_synced, 32'h0);
        master_on = 1'b0;
        tick(3000);
        chk(synced, 32'h0);
        end_of_test();
    end
endmodule
